//--- src/snc_pkg.sv
package snc_pkg;
	// Datapath widths
	localparam int ACC_W = 37;
	localparam int CNT_W = 16;
	localparam int OUT_W = 16;
	localparam int FIFO_DEPTH = 4;
	// Decimation ratios the output slicer knows
	localparam logic [15:0] DECIM_32 = 16'h0020;
	localparam logic [15:0] DECIM_64 = 16'h0040;
	localparam logic [15:0] DECIM_128 = 16'h0080;
	localparam logic [15:0] DECIM_256 = 16'h0100;
	localparam logic [15:0] DECIM_512 = 16'h0200;
	localparam logic [15:0] DECIM_1024 = 16'h0400;
	localparam logic [15:0] DECIM_2048 = 16'h0800;
	localparam logic [15:0] DECIM_4096 = 16'h1000;
	// Right shift of the raw result that leaves its 16 top bits in the low half
	localparam logic [5:0] SHIFT_64 = 6'h02;
	localparam logic [5:0] SHIFT_128 = 6'h05;
	localparam logic [5:0] SHIFT_256 = 6'h08;
	localparam logic [5:0] SHIFT_512 = 6'h0B;
	localparam logic [5:0] SHIFT_1024 = 6'h0E;
	localparam logic [5:0] SHIFT_2048 = 6'h11;
	localparam logic [5:0] SHIFT_4096 = 6'h14;
	// Saturation patterns
	localparam logic [16:0] SAT_PATTERN = 17'h10000;
	localparam logic [15:0] SAT_PATTERN_32 = 16'h8000;
	localparam logic [15:0] SAT_VALUE = 16'hFFFF;
	// Reset values
	localparam logic [ACC_W-1:0] ACC_RESET = 37'h0000000000;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [OUT_W-1:0] WORD_RESET = 16'h0000;
	// Expanded input samples
	localparam logic [ACC_W-1:0] SAMPLE_ONE = 37'h0000000001;
	localparam logic [ACC_W-1:0] SAMPLE_ZERO = 37'h0000000000;
	localparam logic [ACC_W-1:0] SAMPLE_MINUS_ONE = 37'h1FFFFFFFFF;
endpackage : snc_pkg

//--- src/snc_sinc3_filter.sv
// Summary of operation
// - Third-order sinc filter for second-order modulator
// - Response is cube of averaging comb
// - One word per decimation period of modulator clock
// - Deliver top 16 bits of raw result
// - Corner lands at 0.262 of word rate
// - Raw widths 15 to 36 bits, ratios 32-4096
// - Sixteen-bit decimation ratio, 32 up to 4096
// - Sample bitstream on falling modulator clock edge
// - Expand bit to 37 bits, 0/1 or -1/1
// - Three cascaded 37-bit integrators each falling edge
// - Reset clears integrators at once
// - Sixteen-bit counter wraps after ratio minus one
// - Word clock high at half, low at end
// - Three differentiators one edge after word clock fall
// - Ratio 256 slices bits 23:8, saturates
`timescale 1ns/1ps

module snc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] fill_reg;
	logic push;
	logic pop;

	// Full and empty come straight from the fill count
	assign o_in_ready = (fill_reg != (PW+1)'(DEPTH));
	assign o_out_valid = (fill_reg != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_reg[rd_ptr_reg];

	// Storage is written only on a push
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	// Pointers and fill count; wrap relies on DEPTH being a power of two
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + PW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + PW'(1);
			end
			if (push && !pop) begin
				fill_reg <= fill_reg + (PW+1)'(1);
			end else if (pop && !push) begin
				fill_reg <= fill_reg - (PW+1)'(1);
			end
		end
	end

	chk_fifo_no_overfill: assert property (@(posedge i_clk) disable iff (i_rst)
		(fill_reg == (PW+1)'(DEPTH)) |-> !o_in_ready)
		else $error("fifo accepts data while full");
	chk_fifo_count: assert property (@(posedge i_clk) disable iff (i_rst)
		(push && !pop) |=> (fill_reg == $past(fill_reg) + (PW+1)'(1)))
		else $error("fifo count did not rise on push");
	cov_fifo_full: cover property (@(posedge i_clk) disable iff (i_rst) !o_in_ready);
endmodule : snc_fifo

module snc_sinc3_filter #(
	parameter int FIFO_DEPTH = snc_pkg::FIFO_DEPTH
) (
	// System clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Modulator link, on the modulator's own clock
	input wire logic i_filter_clock_in,
	input wire logic i_bitstream_in,
	// Configuration, held steady while running
	input wire logic [15:0] i_decim_factor,
	input wire logic i_twos_comp,
	// Word stream out
	output logic [15:0] o_word,
	output logic o_word_valid,
	input wire logic i_word_ready,
	output logic o_word_strobe,
	output logic o_overrun
);
	localparam int AW = snc_pkg::ACC_W;

	// Link domain state
	logic [1:0] link_rst_sync_reg;
	logic link_rst;
	logic [16:0] cfg_meta_reg;
	logic [16:0] cfg_link_reg;
	logic [15:0] decim_link;
	logic [AW-1:0] expanded_input_sample;
	logic [AW-1:0] integrator_one_reg;
	logic [AW-1:0] integrator_two_reg;
	logic [AW-1:0] integrator_three_reg;
	logic [15:0] count_reg;
	logic word_clk_reg;
	logic count_end;
	logic count_half;
	logic diff_en_reg;
	logic out_en_reg;
	logic [AW-1:0] integ_three_d_reg;
	logic [AW-1:0] diff_one_reg;
	logic [AW-1:0] diff_two_reg;
	logic [AW-1:0] diff_one_d_reg;
	logic [AW-1:0] diff_two_d_reg;
	logic [AW-1:0] final_difference_reg;
	logic [15:0] link_word_reg;
	logic link_toggle_reg;
	// System domain state
	logic [2:0] toggle_sync_reg;
	logic [15:0] hold_word_reg;
	logic hold_valid_reg;
	logic fifo_in_ready;
	logic new_word;
	logic overrun_reg;
	logic strobe_reg;

	// Slice the raw result down to 16 bits with saturation
	function automatic logic [15:0] snc_pick(input logic [AW-1:0] d, input logic [15:0] dec);
		logic [5:0] s;
		logic [AW-1:0] sh;
		s = snc_pkg::SHIFT_256;
		case (dec)
			snc_pkg::DECIM_64: s = snc_pkg::SHIFT_64;
			snc_pkg::DECIM_128: s = snc_pkg::SHIFT_128;
			snc_pkg::DECIM_512: s = snc_pkg::SHIFT_512;
			snc_pkg::DECIM_1024: s = snc_pkg::SHIFT_1024;
			snc_pkg::DECIM_2048: s = snc_pkg::SHIFT_2048;
			snc_pkg::DECIM_4096: s = snc_pkg::SHIFT_4096;
			default: s = snc_pkg::SHIFT_256;
		endcase
		sh = d >> s;
		if (dec == snc_pkg::DECIM_32) begin
			// Only 15 raw bits here, so the word is shifted up one place
			snc_pick = (d[15:0] == snc_pkg::SAT_PATTERN_32) ? snc_pkg::SAT_VALUE
				: {d[14:0], 1'b0};
		end else begin
			snc_pick = (sh[16:0] == snc_pkg::SAT_PATTERN) ? snc_pkg::SAT_VALUE
				: sh[15:0];
		end
	endfunction : snc_pick

	// Link reset asserts at once and releases on a modulator clock edge
	always_ff @(negedge i_filter_clock_in or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			link_rst_sync_reg <= 2'h3;
		end else begin
			link_rst_sync_reg <= {link_rst_sync_reg[0], 1'b0};
		end
	end
	assign link_rst = link_rst_sync_reg[1];

	// Configuration crosses as a level; it must not change mid-run
	always_ff @(negedge i_filter_clock_in or posedge link_rst) begin
		if (link_rst) begin
			cfg_meta_reg <= {1'b0, snc_pkg::DECIM_256};
			cfg_link_reg <= {1'b0, snc_pkg::DECIM_256};
		end else begin
			cfg_meta_reg <= {i_twos_comp, i_decim_factor};
			cfg_link_reg <= cfg_meta_reg;
		end
	end
	assign decim_link = cfg_link_reg[15:0];

	// Bit expansion, optionally signed
	always_comb begin
		if (i_bitstream_in) begin
			expanded_input_sample = snc_pkg::SAMPLE_ONE;
		end else if (cfg_link_reg[16]) begin
			expanded_input_sample = snc_pkg::SAMPLE_MINUS_ONE;
		end else begin
			expanded_input_sample = snc_pkg::SAMPLE_ZERO;
		end
	end

	// Integrators at the modulator rate; wrap-around is harmless in a sinc3
	always_ff @(negedge i_filter_clock_in or posedge link_rst) begin
		if (link_rst) begin
			integrator_one_reg <= snc_pkg::ACC_RESET;
			integrator_two_reg <= snc_pkg::ACC_RESET;
			integrator_three_reg <= snc_pkg::ACC_RESET;
		end else begin
			integrator_one_reg <= integrator_one_reg + expanded_input_sample;
			integrator_two_reg <= integrator_two_reg + integrator_one_reg;
			integrator_three_reg <= integrator_three_reg + integrator_two_reg;
		end
	end

	assign count_end = (count_reg == decim_link - snc_pkg::CNT_ONE);
	assign count_half = (count_reg == (decim_link >> 1) - snc_pkg::CNT_ONE);

	// Decimation counter
	always_ff @(negedge i_filter_clock_in or posedge link_rst) begin
		if (link_rst) begin
			count_reg <= snc_pkg::CNT_RESET;
		end else if (count_end) begin
			count_reg <= snc_pkg::CNT_RESET;
		end else begin
			count_reg <= count_reg + snc_pkg::CNT_ONE;
		end
	end

	// Word clock kept as a flag, not a clock, to avoid a gated domain
	always_ff @(negedge i_filter_clock_in or posedge link_rst) begin
		if (link_rst) begin
			word_clk_reg <= 1'b0;
			diff_en_reg <= 1'b0;
			out_en_reg <= 1'b0;
		end else begin
			if (count_half) begin
				word_clk_reg <= 1'b1;
			end else if (count_end) begin
				word_clk_reg <= 1'b0;
			end
			// Enable lands on the same edge the word clock falls; the comb acts one edge later
			diff_en_reg <= word_clk_reg && count_end;
			out_en_reg <= diff_en_reg;
		end
	end

	// Comb section at the word rate
	always_ff @(negedge i_filter_clock_in or posedge link_rst) begin
		if (link_rst) begin
			integ_three_d_reg <= snc_pkg::ACC_RESET;
			diff_one_reg <= snc_pkg::ACC_RESET;
			diff_two_reg <= snc_pkg::ACC_RESET;
			diff_one_d_reg <= snc_pkg::ACC_RESET;
			diff_two_d_reg <= snc_pkg::ACC_RESET;
			final_difference_reg <= snc_pkg::ACC_RESET;
		end else if (diff_en_reg) begin
			diff_one_reg <= integrator_three_reg - integ_three_d_reg;
			diff_two_reg <= diff_one_reg - diff_one_d_reg;
			final_difference_reg <= diff_two_reg - diff_two_d_reg;
			integ_three_d_reg <= integrator_three_reg;
			diff_one_d_reg <= diff_one_reg;
			diff_two_d_reg <= diff_two_reg;
		end
	end

	// Output word, then a toggle tells the system side it is ready
	always_ff @(negedge i_filter_clock_in or posedge link_rst) begin
		if (link_rst) begin
			link_word_reg <= snc_pkg::WORD_RESET;
			link_toggle_reg <= 1'b0;
		end else if (out_en_reg) begin
			link_word_reg <= snc_pick(final_difference_reg, decim_link);
			link_toggle_reg <= !link_toggle_reg;
		end
	end

	// Toggle synchroniser; the word is stable for many cycles around it
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			toggle_sync_reg <= 3'h0;
		end else begin
			toggle_sync_reg <= {toggle_sync_reg[1:0], link_toggle_reg};
		end
	end
	assign new_word = toggle_sync_reg[2] ^ toggle_sync_reg[1];

	// Holding stage feeds the FIFO; a full FIFO stalls it here
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hold_word_reg <= snc_pkg::WORD_RESET;
			hold_valid_reg <= 1'b0;
		end else if (new_word && (!hold_valid_reg || fifo_in_ready)) begin
			hold_word_reg <= link_word_reg;
			hold_valid_reg <= 1'b1;
		end else if (fifo_in_ready) begin
			hold_valid_reg <= 1'b0;
		end
	end

	// The modulator cannot be paused, so a word that finds no room is lost
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			overrun_reg <= 1'b0;
		end else if (new_word && hold_valid_reg && !fifo_in_ready) begin
			overrun_reg <= 1'b1;
		end
	end

	// Strobe marks each word that reaches the system side
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			strobe_reg <= 1'b0;
		end else begin
			strobe_reg <= new_word;
		end
	end

	snc_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_sys_rst),
		.i_in_valid(hold_valid_reg),
		.o_in_ready(fifo_in_ready),
		.i_in_data(hold_word_reg),
		.o_out_valid(o_word_valid),
		.i_out_ready(i_word_ready),
		.o_out_data(o_word)
	);

	assign o_word_strobe = strobe_reg;
	assign o_overrun = overrun_reg;

	// Checks on the link domain
	chk_count_wrap: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		count_end |=> (count_reg == snc_pkg::CNT_RESET))
		else $error("decimation counter did not wrap");
	chk_count_step: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		(!count_end && $stable(decim_link)) |=> (count_reg == $past(count_reg) + 16'h0001))
		else $error("decimation counter did not advance");
	chk_wclk_rise: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		(count_half && !count_end) |=> word_clk_reg)
		else $error("word clock did not rise at half period");
	chk_wclk_fall: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		count_end |=> !word_clk_reg)
		else $error("word clock did not fall at period end");
	chk_integ_chain: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		$past(!link_rst) |-> (integrator_three_reg ==
		$past(integrator_three_reg) + $past(integrator_two_reg)))
		else $error("third integrator did not add the second");
	chk_integ_first: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		($past(!link_rst) && $past(i_bitstream_in)) |->
		(integrator_one_reg == $past(integrator_one_reg) + 37'h0000000001))
		else $error("high bit did not add one");
	chk_comb_rate: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		diff_en_reg |=> (final_difference_reg == $past(diff_two_reg) - $past(diff_two_d_reg))
		##1 (link_toggle_reg != $past(link_toggle_reg)))
		else $error("comb stage or output word not updated in order");
	chk_comb_hold: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		!diff_en_reg |=> $stable(final_difference_reg))
		else $error("comb stage moved outside the word rate");
	chk_saturate: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		(out_en_reg && decim_link == 16'h0100 && final_difference_reg[24:8] == 17'h10000)
		|=> (link_word_reg == 16'hFFFF))
		else $error("ratio 256 word did not saturate");
	chk_slice: assert property (@(negedge i_filter_clock_in) disable iff (link_rst)
		(out_en_reg && decim_link == 16'h0100 && final_difference_reg[24:8] != 17'h10000)
		|=> (link_word_reg == $past(final_difference_reg[23:8])))
		else $error("ratio 256 word took the wrong bits");
	// Checks on the system domain, plus the saturation cover on the modulator clock
	chk_strobe_once: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_word_strobe |=> !o_word_strobe ##1 !o_word_strobe)
		else $error("word strobe longer than one cycle");
	cov_saturation: cover property (@(negedge i_filter_clock_in) disable iff (link_rst)
		out_en_reg ##1 (link_word_reg == 16'hFFFF));
	cov_word_out: cover property (@(posedge i_clk) disable iff (i_sys_rst)
		o_word_valid && i_word_ready);
	cov_overrun: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_overrun));
endmodule : snc_sinc3_filter

//--- sim/snc_mod_model.sv
`timescale 1ns/1ps
// Behavioural isolated modulator: free-running sample clock plus a ones-density stream
module snc_mod_model (
	// Input level: 0 full negative, 1 full positive, 2 zero input
	input wire logic [1:0] i_mode,
	// Link pins
	output logic o_modulator_clock_out,
	output logic o_modulator_bitstream
);
	// Own clock, odd start offset so it never lines up with the system clock
	initial begin
		o_modulator_clock_out = 1'b0;
		o_modulator_bitstream = 1'b0;
		#1.3;
		forever #3 o_modulator_clock_out = ~o_modulator_clock_out;
	end

	// Bit launched on the rising edge, settled well before the falling edge
	always @(posedge o_modulator_clock_out) begin
		case (i_mode)
			2'h0: o_modulator_bitstream <= 1'b0;
			2'h1: o_modulator_bitstream <= 1'b1;
			default: o_modulator_bitstream <= ~o_modulator_bitstream;
		endcase
	end
endmodule : snc_mod_model

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic i_clk;
	logic i_sys_rst;
	logic link_clk;
	logic link_bit;
	logic [1:0] level_mode;
	logic [15:0] decim;
	logic twos;
	logic ready;
	logic [15:0] word;
	logic word_valid;
	logic word_strobe;
	logic overrun;
	int fail_count;
	int cmp_count;
	int strobe_count;
	int pop_count;

	// Filter under test, fed straight from the modulator model
	snc_sinc3_filter u_dut (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_filter_clock_in(link_clk),
		.i_bitstream_in(link_bit),
		.i_decim_factor(decim),
		.i_twos_comp(twos),
		.o_word(word),
		.o_word_valid(word_valid),
		.i_word_ready(ready),
		.o_word_strobe(word_strobe),
		.o_overrun(overrun)
	);

	snc_mod_model u_mod (
		.i_mode(level_mode),
		.o_modulator_clock_out(link_clk),
		.o_modulator_bitstream(link_bit)
	);

	// System clock, 4 ns
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// Strobe tally, compared against words taken
	always @(posedge i_clk) begin
		if (word_strobe === 1'b1)
			strobe_count++;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	// Configuration only changes under reset, since it crosses as a level
	task automatic start(input logic [15:0] ratio, input logic tc, input logic [1:0] mode);
		@(negedge i_clk);
		i_sys_rst = 1'b1;
		decim = ratio;
		twos = tc;
		level_mode = mode;
		ready = 1'b1;
		repeat (12) @(negedge i_clk);
		check("valid in reset", word_valid, 1'b0);
		check("strobe in reset", word_strobe, 1'b0);
		check("overrun in reset", overrun, 1'b0);
		i_sys_rst = 1'b0;
		strobe_count = 0;
		pop_count = 0;
	endtask : start

	// Bounded wait for the next pop; gap is cycles since the previous call
	task automatic next_word(output logic [15:0] w, output int gap);
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (!(word_valid === 1'b1 && ready === 1'b1) && n < 40000);
		if (n >= 40000) begin
			fail_count++;
			stop_test();
		end
		w = word;
		gap = n;
		pop_count++;
	endtask : next_word

	// Comb pipeline plus sinc3 window: the first four words are unsettled and skipped
	task automatic run_ratio(input logic [15:0] ratio, input logic tc, input logic [1:0] mode,
			input logic [15:0] exp);
		logic [15:0] w;
		int gap;
		start(ratio, tc, mode);
		repeat (4) next_word(w, gap);
		next_word(w, gap);
		check("word value", w, exp);
		check("word spacing", (gap * 2 >= ratio * 3 - 4) && (gap * 2 <= ratio * 3 + 4), 1'b1);
		repeat (3) @(posedge i_clk);
		check("strobes per word", strobe_count, pop_count);
	endtask : run_ratio

	// Half density at every sliced ratio lands exactly on mid scale
	task automatic test_ratio_sweep();
		logic [15:0] r;
		for (int k = 5; k <= 12; k++) begin
			r = 16'h0001 << k;
			run_ratio(r, 1'b0, 2'h2, 16'h8000);
		end
	endtask : test_ratio_sweep

	// Full scale saturates, sign mapping, and an unlisted ratio falling back to the 256 slice
	task automatic test_levels();
		run_ratio(16'h0100, 1'b0, 2'h1, 16'hFFFF);
		run_ratio(16'h0800, 1'b0, 2'h1, 16'hFFFF);
		run_ratio(16'h0020, 1'b1, 2'h1, 16'hFFFF);
		run_ratio(16'h0064, 1'b0, 2'h1, 16'h0F42);
		run_ratio(16'h0100, 1'b0, 2'h0, 16'h0000);
		run_ratio(16'h0100, 1'b1, 2'h0, 16'hFFFF);
		run_ratio(16'h0100, 1'b1, 2'h2, 16'h0000);
	endtask : test_levels

	// Stalled reader: FIFO plus holding stage fill, later words drop, overrun sticks
	task automatic test_overrun();
		int n;
		int pops;
		start(16'h0020, 1'b0, 2'h2);
		ready = 1'b0;
		repeat (600) @(negedge i_clk);
		check("overrun set", overrun, 1'b1);
		n = 0;
		while (word_strobe !== 1'b1 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		ready = 1'b1;
		pops = 0;
		repeat (20) begin
			@(posedge i_clk);
			if (word_valid === 1'b1)
				pops++;
		end
		@(negedge i_clk);
		check("words held", pops, snc_pkg::FIFO_DEPTH + 1);
		check("drained", word_valid, 1'b0);
		check("overrun sticky", overrun, 1'b1);
	endtask : test_overrun

	// Watchdog sized well above the sum of all decimation periods
	initial begin
		#400us;
		fail_count++;
		stop_test();
	end

	initial begin
		fail_count = 0;
		cmp_count = 0;
		strobe_count = 0;
		pop_count = 0;
		i_sys_rst = 1'b1;
		decim = 16'h0100;
		twos = 1'b0;
		level_mode = 2'h2;
		ready = 1'b1;
		test_ratio_sweep();
		test_levels();
		test_overrun();
		stop_test();
	end
endmodule : testbench
